// ---- boot_cfg_device.sv ----
// boot configuration logic of the booting device
// assumes the partner end on the link and a bootloader on the user side
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "boot_map.svh"
module boot_cfg_device
   import boot_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] boot_select_i,
   input wire logic [2:0] config_general_straps_i,
   input wire logic bl_cfg_done_i,
   input wire logic dma_evt_clr_i,
   output logic cpu_stall_o,
   output logic [ADDR_W-1:0] cpu_start_addr_o,
   output logic bootloader_run_o,
   output logic ext_mem_rom8_o,
   output logic i2c_master_en_o,
   output logic i2c_slave_en_o,
   output logic periph_reset_o,
   output logic dma_event_register_o,
   output logic mem_we_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   boot_link_if.dev link
);
   // addresses and words share the table stream, so widths must agree
   if (ADDR_W != 32 || DATA_W != 32) begin : g_width_check
      $error("boot_cfg_device supports 32-bit address and data only");
   end

   typedef enum logic [2:0] {
      d_sample = 3'h0,
      d_run = 3'h1,
      d_stall = 3'h2,
      d_blcfg = 3'h3,
      d_prst = 3'h4,
      d_link = 3'h5,
      d_load = 3'h6
   } dev_state_t;

   typedef struct packed {
      dev_state_t st;
      boot_mode_t mode;
      logic stall;
      logic [ADDR_W-1:0] pc;
      logic bl_run;
      logic rom8;
      logic i2c_m;
      logic i2c_s;
      logic prst;
      logic [7:0] prst_cnt;
      logic idle_tx;
      logic dma_evt;
      logic [3:0] dev_id;
      logic [1:0] port_cfg;
      tbl_phase_t tp;
      logic tbl_rdy;
      logic [ADDR_W-1:0] taddr;
      logic [DATA_W-1:0] tleft;
      logic we;
      logic [ADDR_W-1:0] waddr;
      logic [DATA_W-1:0] wdata;
   } dev_reg_t;

   dev_reg_t r_q;
   dev_reg_t r_d;
   logic [3:0] sel;
   logic [2:0] straps;
   logic sel_valid;
   logic take;
   logic tbl_en;

   boot_strap_sampler u_sampler (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .boot_select_i(boot_select_i),
      .config_general_straps_i(config_general_straps_i),
      .sel_o(sel),
      .straps_o(straps),
      .valid_o(sel_valid)
   );

   // select code to boot path; 0010b and 0011b are undefined
   function automatic boot_mode_t decode_mode(input logic [3:0] s);
      boot_mode_t m;
      m = mode_rsvd;
      if (s[`SEL_SRIO_BIT]) begin
         m = mode_srio;
      end else if (s == `SEL_NONE) begin
         m = mode_none;
      end else if (s == `SEL_HPI || s == `SEL_PCI) begin
         m = mode_host;
      end else if (s == `SEL_ROM8) begin
         m = mode_rom8;
      end else if (s == `SEL_I2CM) begin
         m = mode_i2cm;
      end else if (s == `SEL_I2CS) begin
         m = mode_i2cs;
      end
      return m;
   endfunction

   // tables are only listened to while a loading path is active
   assign tbl_en = (r_q.st == d_load) || (r_q.st == d_link);
   assign take = link.tbl_valid && r_q.tbl_rdy;

   always_comb begin
      r_d = r_q;
      r_d.we = 1'b0;
      r_d.prst = 1'b0;
      r_d.tbl_rdy = tbl_en;

      // host interrupt latch; a set in the clearing cycle wins
      if (link.host_to_cpu_interrupt) begin
         r_d.dma_evt = 1'b1;
      end else if (dma_evt_clr_i) begin
         r_d.dma_evt = 1'b0;
      end

      case (r_q.st)
         d_sample: begin
            if (sel_valid) begin
               r_d.mode = decode_mode(sel);
               r_d.dev_id = {sel[`SEL_ID_MSB_BIT], straps};
               r_d.port_cfg = sel[1:0];
               case (decode_mode(sel))
                  mode_none: begin
                     r_d.pc = `L2_BASE;
                     r_d.stall = 1'b0;
                     r_d.st = d_run;
                  end
                  mode_rom8: begin
                     r_d.pc = `REGION3_BASE;
                     r_d.rom8 = 1'b1;
                     r_d.stall = 1'b0;
                     r_d.st = d_run;
                  end
                  mode_host: begin
                     r_d.pc = `L2_BASE;
                     r_d.st = d_stall;
                  end
                  mode_i2cm: begin
                     r_d.pc = `BOOT_ROM_BASE;
                     r_d.bl_run = 1'b1;
                     r_d.i2c_m = 1'b1;
                     r_d.stall = 1'b0;
                     r_d.st = d_load;
                  end
                  mode_i2cs: begin
                     r_d.pc = `BOOT_ROM_BASE;
                     r_d.bl_run = 1'b1;
                     r_d.i2c_s = 1'b1;
                     r_d.stall = 1'b0;
                     r_d.st = d_load;
                  end
                  mode_srio: begin
                     r_d.pc = `BOOT_ROM_BASE;
                     r_d.bl_run = 1'b1;
                     r_d.stall = 1'b0;
                     r_d.st = d_blcfg;
                  end
                  default: begin
                     r_d.st = d_stall;
                  end
               endcase
            end
         end
         d_stall: begin
            // the host wake ends the stall; reserved codes never leave
            if (link.host_to_cpu_interrupt && r_q.mode == mode_host) begin
               r_d.stall = 1'b0;
               r_d.st = d_run;
            end
         end
         d_blcfg: begin
            // bootloader sets phy and dma registers first
            if (bl_cfg_done_i) begin
               r_d.prst = 1'b1;
               r_d.prst_cnt = `PRST_CYCLES;
               r_d.st = d_prst;
            end
         end
         d_prst: begin
            r_d.prst = 1'b1;
            r_d.prst_cnt = r_q.prst_cnt - 8'h01;
            if (r_q.prst_cnt == 8'h01) begin
               r_d.prst = 1'b0;
               r_d.idle_tx = 1'b1;
               r_d.st = d_link;
            end
         end
         d_link: begin
            // cpu idles until the host wake arrives
            if (link.host_to_cpu_interrupt) begin
               r_d.pc = `L2_BASE;
               r_d.bl_run = 1'b0;
               r_d.st = d_run;
            end
         end
         default: begin
         end
      endcase

      // table engine: destination, length, then that many words
      if (take) begin
         case (r_q.tp)
            tp_addr: begin
               r_d.taddr = link.tbl_word;
               r_d.tp = tp_len;
            end
            tp_len: begin
               r_d.tleft = link.tbl_word;
               if (link.tbl_word != '0) begin
                  r_d.tp = tp_data;
               end else begin
                  r_d.tp = tp_addr;
               end
            end
            default: begin
               r_d.we = 1'b1;
               r_d.waddr = r_q.taddr;
               r_d.wdata = link.tbl_word;
               r_d.taddr = r_q.taddr + `WORD_BYTES;
               r_d.tleft = r_q.tleft - 32'h0000_0001;
               if (r_q.tleft == 32'h0000_0001) begin
                  r_d.tp = tp_addr;
               end
            end
         endcase
      end
   end

   // stall is high from reset until a boot path lets the cpu go
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_q <= '0;
         r_q.stall <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign cpu_stall_o = r_q.stall;
   assign cpu_start_addr_o = r_q.pc;
   assign bootloader_run_o = r_q.bl_run;
   assign ext_mem_rom8_o = r_q.rom8;
   assign i2c_master_en_o = r_q.i2c_m;
   assign i2c_slave_en_o = r_q.i2c_s;
   assign periph_reset_o = r_q.prst;
   assign dma_event_register_o = r_q.dma_evt;
   assign mem_we_o = r_q.we;
   assign mem_addr_o = r_q.waddr;
   assign mem_wdata_o = r_q.wdata;
   assign link.tbl_ready = r_q.tbl_rdy;
   assign link.link_idle = r_q.idle_tx;
   assign link.dev_id = r_q.dev_id;
   assign link.port_cfg = r_q.port_cfg;
endmodule

// ---- boot_host_end.sv ----
// boot partner: table sender and wake source, driven by registers
// assumes a plain register port from software, data read one cycle later
`timescale 1ns/10ps
`include "boot_map.svh"
module boot_host_end
   import boot_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   boot_link_if.host link
);
   if (DATA_W != 32) begin : g_width_check
      $error("boot_host_end supports 32-bit data only");
   end

   typedef struct packed {
      host_state_t st;
      logic [DATA_W-1:0] dest;
      logic [DATA_W-1:0] len;
      logic [DATA_W-1:0] left;
      logic [DATA_W-1:0] hold;
      logic hold_full;
      logic vld;
      logic [DATA_W-1:0] word;
      logic bell;
      logic known;
      logic [3:0] dev_id;
      logic [1:0] port_cfg;
      logic [DATA_W-1:0] rdata;
   } host_reg_t;

   host_reg_t r_q;
   host_reg_t r_d;
   logic sent;

   assign sent = r_q.vld && link.tbl_ready;

   always_comb begin
      r_d = r_q;
      r_d.bell = 1'b0;
      r_d.rdata = '0;
      // idle symbols mean the device is up; read its identity
      if (link.link_idle && !r_q.known) begin
         r_d.known = 1'b1;
         r_d.dev_id = link.dev_id;
         r_d.port_cfg = link.port_cfg;
      end
      if (reg_wr_i) begin
         if (reg_addr_i == `HREG_CTRL) begin
            if (reg_wdata_i[`CTRL_SEND_BIT] && r_q.st == h_idle) begin
               r_d.st = h_addr;
               r_d.vld = 1'b1;
               r_d.word = r_q.dest;
            end
            r_d.bell = reg_wdata_i[`CTRL_BELL_BIT];
         end else if (reg_addr_i == `HREG_DEST) begin
            r_d.dest = reg_wdata_i;
         end else if (reg_addr_i == `HREG_LEN) begin
            r_d.len = reg_wdata_i;
         end else if (!r_q.hold_full) begin
            r_d.hold = reg_wdata_i; // dropped while the hold is full
            r_d.hold_full = 1'b1;
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == `HREG_CTRL) begin
            r_d.rdata = {20'h00000, 2'h0, r_q.port_cfg, r_q.dev_id,
                         1'b0, r_q.hold_full, r_q.known, r_q.st != h_idle};
         end else if (reg_addr_i == `HREG_DEST) begin
            r_d.rdata = r_q.dest;
         end else if (reg_addr_i == `HREG_LEN) begin
            r_d.rdata = r_q.len;
         end
      end
      case (r_q.st)
         h_addr: begin
            if (sent) begin
               r_d.word = r_q.len;
               r_d.left = r_q.len;
               r_d.st = h_len;
            end
         end
         h_len: begin
            if (sent) begin
               r_d.vld = 1'b0;
               r_d.st = (r_q.left == '0) ? h_idle : h_data;
            end
         end
         h_data: begin
            // one word in flight; the hold moves into it only once the previous word is sent
            if (r_q.vld) begin
               if (sent) begin
                  r_d.vld = 1'b0;
                  r_d.left = r_q.left - 32'h0000_0001;
                  if (r_q.left == 32'h0000_0001) begin
                     r_d.st = h_idle;
                  end
               end
            end else if (r_q.hold_full) begin
               r_d.vld = 1'b1;
               r_d.word = r_q.hold;
               r_d.hold_full = 1'b0;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign reg_rdata_o = r_q.rdata;
   assign link.tbl_valid = r_q.vld;
   assign link.tbl_word = r_q.word;
   assign link.host_to_cpu_interrupt = r_q.bell;
endmodule

// ---- boot_link_if.sv ----
// link between the booting device and its boot partner
// assumes one shared clock; both ends drive from flops
`timescale 1ns/10ps
interface boot_link_if #(parameter int DATA_W = 32);
   logic tbl_valid;
   logic [DATA_W-1:0] tbl_word;
   logic tbl_ready;
   logic host_to_cpu_interrupt;
   logic link_idle;
   logic [3:0] dev_id;
   logic [1:0] port_cfg;
   modport dev (
      input tbl_valid,
      input tbl_word,
      input host_to_cpu_interrupt,
      output tbl_ready,
      output link_idle,
      output dev_id,
      output port_cfg
   );
   modport host (
      output tbl_valid,
      output tbl_word,
      output host_to_cpu_interrupt,
      input tbl_ready,
      input link_idle,
      input dev_id,
      input port_cfg
   );
endinterface

// ---- boot_link_properties.sv ----
// concurrent checks on the link joining device end and host end
// assumes one clock domain and the link signals wired in by name
`timescale 1ns/10ps
module boot_link_properties #(
   parameter int DATA_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic tbl_valid,
   input wire logic [DATA_W-1:0] tbl_word,
   input wire logic tbl_ready,
   input wire logic host_to_cpu_interrupt,
   input wire logic link_idle,
   input wire logic [3:0] dev_id,
   input wire logic [1:0] port_cfg
);
   logic [2:0] age_q;
   logic [2:0] age_d;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // saturating age since reset release; the pins settle at edge 2
   always_comb begin
      age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         age_q <= 3'h0;
      end else begin
         age_q <= age_d;
      end
   end

   valid_held_a: assert property (tbl_valid && !tbl_ready |=> tbl_valid)
      else $error("table word withdrawn before it was taken");
   word_held_a: assert property (tbl_valid && !tbl_ready |=> $stable(tbl_word))
      else $error("table word changed while waiting");
   wake_pulse_a: assert property (host_to_cpu_interrupt |=> !host_to_cpu_interrupt)
      else $error("wake interrupt longer than one cycle");
   id_stable_a: assert property (age_q >= 3'h3 |-> $stable(dev_id))
      else $error("device id changed after sampling");
   cfg_stable_a: assert property (age_q >= 3'h3 |-> $stable(port_cfg))
      else $error("port configuration changed after sampling");
   idle_sticky_a: assert property (link_idle |=> link_idle)
      else $error("idle symbols stopped");
   idle_late_a: assert property (age_q <= 3'h3 |-> !link_idle)
      else $error("idle symbols before peripheral reset");
   ready_late_a: assert property (age_q <= 3'h1 |-> !tbl_ready)
      else $error("table load ready before pins sampled");

   load_c: cover property (tbl_valid && tbl_ready);
   wake_c: cover property (host_to_cpu_interrupt);
   idle_c: cover property ($rose(link_idle));
endmodule

// ---- boot_map.svh ----
// boot configuration constants: addresses, mode codes, register offsets
// assumes inclusion by bare name from every design file that needs them
`ifndef BOOT_MAP_SVH
`define BOOT_MAP_SVH
`define SEL_NONE 4'h0
`define SEL_HPI 4'h1
`define SEL_ROM8 4'h4
`define SEL_I2CM 4'h5
`define SEL_I2CS 4'h6
`define SEL_PCI 4'h7
`define SEL_SRIO_BIT 3
`define SEL_ID_MSB_BIT 2
`define L2_BASE 32'h0080_0000
`define REGION3_BASE 32'hb000_0000
`define BOOT_ROM_BASE 32'h0010_0000
`define WORD_BYTES 32'h0000_0004
`define PRST_CYCLES 8'h04
`define HREG_CTRL 2'h0
`define HREG_DEST 2'h1
`define HREG_LEN 2'h2
`define HREG_DATA 2'h3
`define CTRL_SEND_BIT 0
`define CTRL_BELL_BIT 1
`endif

// ---- boot_mode_select_tb_top.sv ----
// self-checking bench: both ends joined by the link, host end by registers
// assumes the map header and package of the design are compiled first
`timescale 1ns/10ps
`include "boot_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module boot_mode_select_tb_top;
   import boot_pkg::*;
   logic ref_clk_i, rst_n_i, bl_done, evt_clr, wr, rd, stall, run, rom8, im, is, prst, evt, we;
   logic [3:0] sel;
   logic [2:0] straps;
   logic [1:0] addr;
   logic [31:0] wdata, rdata, start, maddr, mdata, dest;
   logic [31:0] words [2];
   int err_total, tests_run, cycles, nwr;
   boot_link_if #(.DATA_W(32)) u_link ();
   boot_cfg_device u_boot_cfg_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .boot_select_i(sel), .config_general_straps_i(straps), .bl_cfg_done_i(bl_done),
      .dma_evt_clr_i(evt_clr), .cpu_stall_o(stall), .cpu_start_addr_o(start),
      .bootloader_run_o(run), .ext_mem_rom8_o(rom8), .i2c_master_en_o(im),
      .i2c_slave_en_o(is), .periph_reset_o(prst), .dma_event_register_o(evt),
      .mem_we_o(we), .mem_addr_o(maddr), .mem_wdata_o(mdata), .link(u_link));
   boot_host_end u_boot_host_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .link(u_link));
   boot_link_properties u_boot_link_properties (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .tbl_valid(u_link.tbl_valid), .tbl_word(u_link.tbl_word),
      .tbl_ready(u_link.tbl_ready), .host_to_cpu_interrupt(u_link.host_to_cpu_interrupt),
      .link_idle(u_link.link_idle), .dev_id(u_link.dev_id), .port_cfg(u_link.port_cfg));

   // 50 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // every memory write must land at dest plus four per word
   always @(posedge ref_clk_i) begin
      if (we === 1'b1) begin
         `CHK(maddr, dest + 32'(nwr) * `WORD_BYTES)
         `CHK(mdata, words[nwr])
         nwr++;
      end
   end

   // hang guard; the whole run needs well under two thousand cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // one-cycle strobe on the event clear or on the bootloader done line
   task automatic pulse(input logic clr);
      @(posedge ref_clk_i);
      if (clr) begin
         evt_clr <= 1'b1;
      end else begin
         bl_done <= 1'b1;
      end
      @(posedge ref_clk_i);
      evt_clr <= 1'b0;
      bl_done <= 1'b0;
   endtask

   // pins are set while reset is held and stay put through release
   task automatic boot(input logic [3:0] s, input logic [2:0] st);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      sel <= s;
      straps <= st;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   // flags: stall, run, rom8, i2c master, i2c slave
   task automatic mode(input logic [3:0] s, input logic [4:0] f, input logic [31:0] a);
      boot(s, 3'h0);
      `CHK({stall, run, rom8, im, is}, f)
      `CHK(start, a)
   endtask

   initial begin
      logic [31:0] r;
      int n;
      {rst_n_i, bl_done, evt_clr, wr, rd, addr, wdata, sel, straps} = '0;
      {err_total, tests_run, cycles, nwr} = '0;
      dest = 32'h0080_0100;
      words[0] = 32'hdead_0001;
      words[1] = 32'h5a5a_a5a5;
      mode(`SEL_NONE, 5'b00000, `L2_BASE);
      mode(`SEL_ROM8, 5'b00100, `REGION3_BASE);
      mode(`SEL_I2CS, 5'b01001, `BOOT_ROM_BASE);
      mode(`SEL_I2CM, 5'b01010, `BOOT_ROM_BASE);
      // table: destination, length, then each data word
      reg_wr(`HREG_DEST, dest);
      reg_wr(`HREG_LEN, 32'h0000_0002);
      reg_wr(`HREG_CTRL, 32'h0000_0001);
      for (int i = 0; i < 2; i++) begin
         repeat (4) @(posedge ref_clk_i);
         reg_wr(`HREG_DATA, words[i]);
      end
      repeat (6) @(posedge ref_clk_i);
      `CHK(nwr, 2)
      // undefined select codes keep the cpu held even after a wake
      mode(4'h2, 5'b10000, 32'h0000_0000);
      reg_wr(`HREG_CTRL, 32'h0000_0002);
      repeat (4) @(posedge ref_clk_i);
      `CHK(stall, 1'b1)
      // both host boots stall until the wake, then run from l2
      for (int i = 0; i < 2; i++) begin
         mode(i == 0 ? `SEL_HPI : `SEL_PCI, 5'b10000, `L2_BASE);
         `CHK(evt, 1'b0)
         reg_wr(`HREG_CTRL, 32'h0000_0002);
         // clear meets the wake in one cycle; the set must win
         evt_clr <= 1'b1;
         @(posedge ref_clk_i);
         evt_clr <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
         `CHK({stall, start}, {1'b0, `L2_BASE})
         `CHK(evt, 1'b1)
         pulse(1'b1);
         #1 `CHK(evt, 1'b0)
      end
      // every rapidio code: id from select bit 2 and straps, config from bits 1..0
      for (int c = 8; c < 16; c++) begin
         boot(4'(c), 3'(c) ^ 3'h5);
         `CHK({u_link.dev_id, u_link.port_cfg}, {c[2], 3'(c) ^ 3'h5, c[1:0]})
         `CHK({stall, run, rom8, im, is, u_link.link_idle}, 6'b010000)
         pulse(1'b0);
         // first sample lands in the cycle the reset pulse starts
         n = 0;
         repeat (8) begin
            #1 n += int'(prst);
            @(posedge ref_clk_i);
         end
         `CHK(n, 4)
         `CHK(u_link.link_idle, 1'b1)
         // host learns the identity only once idle symbols flow
         reg_rd(`HREG_CTRL, r);
         `CHK(r[9:1], {c[1:0], c[2], 3'(c) ^ 3'h5, 3'b001})
      end
      reg_wr(`HREG_CTRL, 32'h0000_0002);
      repeat (4) @(posedge ref_clk_i);
      #1 `CHK({run, start}, {1'b0, `L2_BASE})
      report_and_stop();
   end
endmodule

// ---- boot_pkg.sv ----
// boot configuration types shared by both ends
// assumes nothing beyond the map header
package boot_pkg;
   typedef enum logic [2:0] {
      mode_none = 3'h0,
      mode_host = 3'h1,
      mode_rom8 = 3'h2,
      mode_i2cm = 3'h3,
      mode_i2cs = 3'h4,
      mode_srio = 3'h5,
      mode_rsvd = 3'h6
   } boot_mode_t;
   typedef enum logic [1:0] {
      tp_addr = 2'h0,
      tp_len = 2'h1,
      tp_data = 2'h2
   } tbl_phase_t;
   typedef enum logic [1:0] {
      h_idle = 2'h0,
      h_addr = 2'h1,
      h_len = 2'h2,
      h_data = 2'h3
   } host_state_t;
endpackage

// ---- boot_strap_sampler.sv ----
// captures boot select and straps once after reset release
// assumes pins are synchronous to the clock and stable around release
`timescale 1ns/10ps
`include "boot_map.svh"
module boot_strap_sampler (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] boot_select_i,
   input wire logic [2:0] config_general_straps_i,
   output logic [3:0] sel_o,
   output logic [2:0] straps_o,
   output logic valid_o
);
   typedef struct packed {
      logic [3:0] sel;
      logic [2:0] straps;
      logic valid;
   } smp_t;
   smp_t s_q;
   smp_t s_d;

   // pins taken by the clock, never by reset, then frozen
   always_comb begin
      s_d = s_q;
      if (!s_q.valid) begin
         s_d.sel = boot_select_i;
         s_d.straps = config_general_straps_i;
         s_d.valid = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sel_o = s_q.sel;
   assign straps_o = s_q.straps;
   assign valid_o = s_q.valid;
endmodule
